// ==== design/dpms_pkg.sv ====
// Package for the debug port mode select block: constants and carrier structs.
// Assumes a single system clock domain plus the probe's test clock.
package dpms_pkg;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [1:0] DPMS_LOW_CYCLES_MIN = 2'h2;
    localparam logic [1:0] DPMS_LOW_CNT_RST = 2'h0;
    localparam int DPMS_SYNC_STAGES = 2;
    localparam logic DPMS_PULL_LEVEL = 1'b1;

    typedef enum logic [1:0] {
        DPMS_ST_STRAP = 2'b00,
        DPMS_ST_INSTR = 2'b01,
        DPMS_ST_TWO_WIRE = 2'b10
    } dpms_mode_t;

    // Pins as seen by the probe side; pulled up when undriven
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } dpms_pins_in_t;

    // Two-signal form of a two-way or tristate pin
    typedef struct packed {
        logic value;
        logic enable;
    } dpms_drive_t;

endpackage

// ==== design/dpms_top.sv ====
// Debug port mode select: strap-time choice between the instrumentation unit
// and the two-wire debug mode, plus the test pin edge discipline.
// Assumes the test clock is free of glitches and slower than half clock_in.
//
// How it works
// - Test clock high at release: unit off
// - Unit off: two-wire mode, test clock serial
// - Unit off: data in becomes debug line
// - Undriven test inputs read as one
// - Mode select sampled on test rising edge
// - Unit on: data in sampled, input only
// - Data out changes on falling edges only
// - Unit on: trigger event drives high trigger pulse
// - Trigger pin floats when not pulsing
// - No boundary scan register offered
`timescale 1ns/10ps
`default_nettype none
module dpms_top
    import dpms_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic tck_in,
    input wire logic tck_driven_in,
    input wire logic tms_in,
    input wire logic tms_driven_in,
    input wire logic tdi_in,
    input wire logic tdi_driven_in,
    input wire logic tdo_bit_in,
    input wire logic trigger_event_in,
    input wire logic debug_line_value_in,
    input wire logic debug_line_drive_in,
    output logic instr_enable_out,
    output logic two_wire_enable_out,
    output logic tms_sample_out,
    output logic tdi_sample_out,
    output logic debug_line_sample_out,
    output logic serial_clock_rise_out,
    output logic tdo_out,
    output logic tdi_out,
    output logic tdi_oe_out,
    output logic trigger_out_out,
    output logic trigger_out_oe_out
);
    import dpms_pkg::*;

    // ------------------------------------------------------------------
    // Pull-ups: an undriven pin resolves to one
    // ------------------------------------------------------------------
    dpms_pins_in_t pins;
    always_comb begin
        pins.tck = tck_driven_in ? tck_in : DPMS_PULL_LEVEL;
        pins.tms = tms_driven_in ? tms_in : DPMS_PULL_LEVEL;
        pins.tdi = tdi_driven_in ? tdi_in : DPMS_PULL_LEVEL;
    end

    // ------------------------------------------------------------------
    // Test clock into the system domain
    // ------------------------------------------------------------------
    // No reset here: the strap is judged at release from samples taken while
    // reset is held, so the pin must keep flowing through the stages during reset.
    logic tck_s1_reg, tck_s2_reg, tck_s3_reg;
    logic tck_s1_next, tck_s2_next, tck_s3_next;
    logic tdi_s1_reg, tdi_s2_reg, tdi_s1_next, tdi_s2_next;
    always_comb begin
        tck_s1_next = pins.tck;
        tck_s2_next = tck_s1_reg;
        tck_s3_next = tck_s2_reg;
        tdi_s1_next = pins.tdi;
        tdi_s2_next = tdi_s1_reg;
    end
    always_ff @(posedge clock_in) begin
        tck_s1_reg <= tck_s1_next;
        tck_s2_reg <= tck_s2_next;
        tck_s3_reg <= tck_s3_next;
        tdi_s1_reg <= tdi_s1_next;
        tdi_s2_reg <= tdi_s2_next;
    end
    logic tck_rise;
    assign tck_rise = tck_s2_reg & ~tck_s3_reg;

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // A shift of synced low samples, free of reset, settles to known values
    // within a few edges of power-up; mode is caught at release.
    localparam int LOW_W = int'(DPMS_LOW_CYCLES_MIN);
    logic [LOW_W-1:0] low_hist_reg, low_hist_next;
    logic strap_low;
    always_comb begin
        low_hist_next = {low_hist_reg[LOW_W-2:0], ~tck_s2_reg};
    end
    always_ff @(posedge clock_in) begin
        low_hist_reg <= low_hist_next;
    end
    assign strap_low = &low_hist_reg;

    dpms_mode_t mode_reg, mode_next;
    always_comb begin
        mode_next = mode_reg;
        if (mode_reg == DPMS_ST_STRAP) begin
            if (strap_low) begin
                mode_next = DPMS_ST_INSTR;
            end else begin
                mode_next = DPMS_ST_TWO_WIRE;
            end
        end
    end
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_reg <= DPMS_ST_STRAP;
        end else begin
            mode_reg <= mode_next;
        end
    end
    logic instr_on, wire_on;
    assign instr_on = (mode_reg == DPMS_ST_INSTR);
    assign wire_on = (mode_reg == DPMS_ST_TWO_WIRE);

    // ------------------------------------------------------------------
    // System-side outputs
    // ------------------------------------------------------------------
    // The instrumentation unit's enable is held low in two-wire mode, so its
    // pin samples and data out hold; no boundary scan register exists behind the port.
    logic instr_en_reg, wire_en_reg, rise_reg, line_samp_reg;
    logic trig_reg, trig_oe_reg;
    logic instr_en_next, wire_en_next, rise_next, line_samp_next;
    logic trig_next, trig_oe_next;
    always_comb begin
        instr_en_next = instr_on;
        wire_en_next = wire_on;
        rise_next = tck_rise & wire_on;
        line_samp_next = line_samp_reg;
        if (tck_rise && wire_on) begin
            line_samp_next = tdi_s2_reg;
        end
        trig_next = trigger_event_in & instr_on;
        trig_oe_next = trigger_event_in & instr_on;
    end
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            instr_en_reg <= 1'b0;
            wire_en_reg <= 1'b0;
            rise_reg <= 1'b0;
            line_samp_reg <= 1'b1;
            trig_reg <= 1'b0;
            trig_oe_reg <= 1'b0;
        end else begin
            instr_en_reg <= instr_en_next;
            wire_en_reg <= wire_en_next;
            rise_reg <= rise_next;
            line_samp_reg <= line_samp_next;
            trig_reg <= trig_next;
            trig_oe_reg <= trig_oe_next;
        end
    end
    assign instr_enable_out = instr_en_reg;
    assign two_wire_enable_out = wire_en_reg;
    assign serial_clock_rise_out = rise_reg;
    assign debug_line_sample_out = line_samp_reg;
    assign trigger_out_out = trig_reg;
    assign trigger_out_oe_out = trig_oe_reg;

    // Debug line drive: only in two-wire mode; input only otherwise
    dpms_drive_t line_reg, line_next;
    always_comb begin
        line_next.value = debug_line_value_in;
        line_next.enable = debug_line_drive_in & wire_on;
    end
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            line_reg <= '0;
        end else begin
            line_reg <= line_next;
        end
    end
    assign tdi_out = line_reg.value;
    assign tdi_oe_out = line_reg.enable;

    // ------------------------------------------------------------------
    // Test clock domain
    // ------------------------------------------------------------------
    // Enable crosses as a level; it is static long before the first edge.
    logic en_t1_reg, en_t2_reg, en_t1_next, en_t2_next;
    logic tms_reg, tdi_reg, tms_next, tdi_next;
    always_comb begin
        en_t1_next = instr_en_reg;
        en_t2_next = en_t1_reg;
        tms_next = en_t2_reg ? pins.tms : tms_reg;
        tdi_next = en_t2_reg ? pins.tdi : tdi_reg;
    end
    always_ff @(posedge pins.tck or negedge rst_b_in) begin
        if (!rst_b_in) begin
            en_t1_reg <= 1'b0;
            en_t2_reg <= 1'b0;
            tms_reg <= 1'b1;
            tdi_reg <= 1'b1;
        end else begin
            en_t1_reg <= en_t1_next;
            en_t2_reg <= en_t2_next;
            tms_reg <= tms_next;
            tdi_reg <= tdi_next;
        end
    end
    assign tms_sample_out = tms_reg;
    assign tdi_sample_out = tdi_reg;

    logic tdo_reg, tdo_next;
    always_comb begin
        tdo_next = en_t2_reg ? tdo_bit_in : tdo_reg;
    end
    always_ff @(negedge pins.tck or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tdo_reg <= 1'b0;
        end else begin
            tdo_reg <= tdo_next;
        end
    end
    assign tdo_out = tdo_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    mode_exclusive_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !(instr_enable_out && two_wire_enable_out))
        else $error("both debug modes enabled");
    mode_stable_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (mode_reg != DPMS_ST_STRAP) |=> $stable(mode_reg))
        else $error("debug mode changed after strap");
    line_oe_mode_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        tdi_oe_out |-> two_wire_enable_out)
        else $error("debug line driven outside two-wire mode");
    trig_pulse_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (trigger_event_in && instr_on) |=> (trigger_out_out && trigger_out_oe_out))
        else $error("trigger pulse missing");
    trig_float_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !trigger_out_oe_out |-> !trigger_out_out)
        else $error("trigger driven while floating");
    rise_wire_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        serial_clock_rise_out |-> ($past(tck_s2_reg) && !$past(tck_s3_reg)))
        else $error("serial clock strobe without edge");
    tdo_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $changed(tdo_out) |-> !pins.tck)
        else $error("data out moved while test clock high");
    tms_hold_a: assert property (@(posedge pins.tck) disable iff (!rst_b_in)
        !en_t2_reg |=> $stable(tms_reg))
        else $error("mode select sampled while unit off");

endmodule
`default_nettype wire

// ==== tb/dpms_probe.sv ====
// Probe model standing on the test pins of the debug port.
// Assumes the bench calls its tasks; released pins float up to one.
`timescale 1ns/10ps
`default_nettype none
module dpms_probe (
    output logic tck_out,
    output logic tck_drv_out,
    output logic tms_out,
    output logic tms_drv_out,
    output logic tdi_out,
    output logic tdi_drv_out
);
    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    initial begin
        tck_out = 1'b1;
        tck_drv_out = 1'b0;
        tms_out = 1'b1;
        tms_drv_out = 1'b0;
        tdi_out = 1'b1;
        tdi_drv_out = 1'b0;
    end
    // Strap level for reset; a released clock pin is pulled high
    task automatic strap(input logic low);
        tck_drv_out = low;
        tck_out = !low;
    endtask
    // Released lines show the pull-up level, never the last value
    task automatic put(input logic drv, input logic tms, input logic tdi);
        tms_drv_out = drv;
        tdi_drv_out = drv;
        tms_out = drv ? tms : 1'b1;
        tdi_out = drv ? tdi : 1'b1;
    endtask
    // Half period of 40 ns keeps tck at twice the system period
    task automatic edge_to(input logic lvl);
        tck_drv_out = 1'b1;
        tck_out = lvl;
        #40;
    endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the debug port mode select block.
// Assumes the probe model drives the test pins; the bench owns the rest.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dpms_pkg::*;
    // Row bits: strap low, unit on, two-wire on, trigger seen, line oe
    localparam logic [4:0] ROWS [2] = '{5'h1a, 5'h05};
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic tdo_bit_in = 1'b0;
    logic trigger_event_in = 1'b0;
    logic dl_val;
    logic dl_drv = 1'b0;
    logic p_tck, p_tckd, p_tms, p_tmsd, p_tdi, p_tdid, tdi_pin;
    logic instr, two, tms_s, tdi_s, dl_s, rise, tdo, tdi_dev, tdi_oe, trig, trig_oe;
    int n_errors = 0;
    int n_tests = 0;

    always #20 clock_in = ~clock_in;
    // Wire level: the device wins while it drives the line
    assign tdi_pin = tdi_oe ? tdi_dev : p_tdi;

    dpms_probe u_dpms_probe (.tck_out(p_tck), .tck_drv_out(p_tckd), .tms_out(p_tms),
        .tms_drv_out(p_tmsd), .tdi_out(p_tdi), .tdi_drv_out(p_tdid));
    dpms_top u_dpms_top (.clock_in(clock_in), .rst_b_in(rst_b_in), .tck_in(p_tck),
        .tck_driven_in(p_tckd), .tms_in(p_tms), .tms_driven_in(p_tmsd), .tdi_in(tdi_pin),
        .tdi_driven_in(p_tdid | tdi_oe), .tdo_bit_in(tdo_bit_in),
        .trigger_event_in(trigger_event_in), .debug_line_value_in(dl_val),
        .debug_line_drive_in(dl_drv), .instr_enable_out(instr), .two_wire_enable_out(two),
        .tms_sample_out(tms_s), .tdi_sample_out(tdi_s), .debug_line_sample_out(dl_s),
        .serial_clock_rise_out(rise), .tdo_out(tdo), .tdi_out(tdi_dev),
        .tdi_oe_out(tdi_oe), .trigger_out_out(trig), .trigger_out_oe_out(trig_oe));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Strap is set as reset starts so the low samples have time to fill
    task automatic do_reset(input logic low);
        @(posedge clock_in);
        rst_b_in <= 1'b0;
        u_dpms_probe.strap(low);
        repeat (4) @(posedge clock_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
    endtask
    task automatic tbit;
        u_dpms_probe.edge_to(1'b1);
        u_dpms_probe.edge_to(1'b0);
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        dl_val <= 1'b0;
        foreach (ROWS[i]) begin
            do_reset(ROWS[i][4]);
            chk({instr, two}, ROWS[i][3:2]);
            @(posedge clock_in);
            dl_drv <= 1'b1;
            dl_val <= 1'b1;
            trigger_event_in <= 1'b1;
            @(posedge clock_in);
            trigger_event_in <= 1'b0;
            @(negedge clock_in);
            chk({trig, trig_oe}, {2{ROWS[i][1]}});
            chk({tdi_oe, tdi_dev}, {ROWS[i][0], 1'b1});
            @(posedge clock_in);
            dl_drv <= 1'b0;
            dl_val <= 1'b0;
            @(negedge clock_in);
            chk({trig, trig_oe}, 2'b00);
        end
        // Two-wire: tck becomes the serial clock, tdi the data line
        u_dpms_probe.put(1'b1, 1'b0, 1'b0);
        #7;
        u_dpms_probe.edge_to(1'b0);
        u_dpms_probe.edge_to(1'b1);
        for (int k = 0; k < 8 && rise !== 1'b1; k++) @(negedge clock_in);
        chk({rise, dl_s}, 2'b10);
        @(negedge clock_in);
        chk({rise, tms_s}, 2'b01);
        // Unit mode again after a reset in mid-run
        do_reset(1'b1);
        chk({instr, two}, 2'b10);
        u_dpms_probe.put(1'b1, 1'b0, 1'b0);
        #7;
        repeat (3) tbit();
        chk({tms_s, tdi_s}, 2'b00);
        u_dpms_probe.put(1'b0, 1'b0, 1'b0);
        tbit();
        chk({tms_s, tdi_s}, 2'b11);
        @(posedge clock_in);
        tdo_bit_in <= 1'b1;
        #7;
        u_dpms_probe.edge_to(1'b1);
        chk({tdo, tdi_oe}, 2'b00);
        u_dpms_probe.edge_to(1'b0);
        chk({tdo, tdi_oe}, 2'b10);
        tally_and_finish();
    end

    // Whole run is a few microseconds; this span is far beyond it
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
